/* File: dvmap_pkg.sv */
// Purpose: shared constants and types for the message address packer and unpacker
// Assumes: address channel width is ADDR_MAX (48), the largest physical width; narrower PA_W values are masked
// Notes:
package dvmap_pkg;

	localparam int ADDR_MAX = 48;
	localparam int VA_MAX   = 57;

	// first-part and second-part field positions
	localparam int F_MORE    = 0;
	localparam int F_SPACEOK = 5;
	localparam int F_MACHOK  = 6;
	localparam int F_TYPE_LO = 12;
	localparam int F_MID_LO  = 24;
	localparam int F_SID_LO  = 16;
	localparam int F_SIDH_LO = 32;
	localparam int F_HI1_LO  = 40;
	localparam int F_HI2_LO  = 44;
	localparam int S_VA40    = 3;
	localparam int S_LOW_LO  = 4;
	localparam int S_LOW_HI  = 31;
	localparam int S_UP_LO   = 32;
	localparam int F_CTRL_LO = 1;
	localparam int F_CTRL_HI = 11;

	localparam logic [2:0] MSG_HINT = 3'h6;

	// virtual-address source bit positions
	localparam int VA_A1 = 45;
	localparam int VA_A2 = 53;
	localparam int VA_B1 = 41;
	localparam int VA_B2 = 49;
	localparam int VA_40 = 40;
	localparam int VA_IDX_LO = 12;

	typedef logic [ADDR_MAX-1:0] dvmap_addr_t;
	typedef logic [VA_MAX-1:0]   dvmap_va_t;

	// true if pairing is supported for the chosen message version
	function automatic logic dvmap_pair_ok(input int pw, input int vw, input logic newer);
		dvmap_pair_ok = ((pw == 32 || pw == 40) && vw == 32)
			|| (newer && ((pw == 40 && vw == 41) || (pw == 44 && vw == 49)
			|| (pw == 48 && vw == 57)));
	endfunction : dvmap_pair_ok

	function automatic dvmap_addr_t dvmap_mask(input int w);
		dvmap_mask = dvmap_addr_t'((49'h1 << w) - 49'h1);
	endfunction : dvmap_mask

endpackage : dvmap_pkg

/* File: dvmap_if.sv */
`timescale 1ns/10ps
`default_nettype none
// carries the one or two address beats from sender to receiver
interface dvmap_if
	import dvmap_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b
);
	logic        valid;
	logic        ready;
	dvmap_addr_t addr;
	logic        last;

	modport sender   (input core_clk, rst_b, ready, output valid, addr, last);
	modport receiver (input core_clk, rst_b, valid, addr, last, output ready);
endinterface : dvmap_if
`default_nettype wire

/* File: dvmap_packer.sv */
`timescale 1ns/10ps
`default_nettype none
// Purpose: builds one- or two-beat message addresses from fields
// Assumes: requests taken only while reqReady is high
// Notes: unsupported width pairing blocks every request
module dvmap_packer
	import dvmap_pkg::*;
#(
	parameter int  PA_W   = 40,
	parameter int  VA_W   = 32,
	parameter bit  NEWER  = 1'b1,
	parameter bit  SID16  = 1'b0
)
(
	// link
	dvmap_if.sender         link,
	// request
	input  wire logic       reqValid,
	input  wire logic       physOp,
	input  wire logic       twoPart,
	input  wire logic [11:0] ctrlBits,
	input  wire logic [2:0] msgType,
	input  wire logic       machValid,
	input  wire logic       spaceValid,
	input  wire logic [7:0] virtual_machine_id,
	input  wire logic [15:0] address_space_id,
	input  wire dvmap_va_t  virtual_address_bits,
	input  wire dvmap_addr_t physical_address_bits,
	output logic            reqReady,
	output logic            pairBad
);
	typedef enum logic [1:0] {IDLE, BEAT1, BEAT2} dvmap_st_e;
	typedef struct packed {
		dvmap_st_e   st;
		logic        valid;
		logic        last;
		dvmap_addr_t addr;
		dvmap_addr_t second;
		logic        ready;
		logic        bad;
	} dvmap_pk_s;

	localparam logic PAIR_OK = dvmap_pair_ok(PA_W, VA_W, NEWER);
	localparam logic HAS_SIDH = (PA_W >= 40);

	dvmap_pk_s q, next_q;
	dvmap_addr_t b1, b2;
	logic hintType;

	always_comb
	begin
		hintType = (msgType == MSG_HINT);
		b1 = '0;
		b2 = '0;
		b1[F_MORE] = twoPart;
		b1[F_CTRL_HI:F_CTRL_LO] = ctrlBits[F_CTRL_HI:F_CTRL_LO];
		b1[F_TYPE_LO +: 3] = msgType;
		b1[F_MACHOK] = machValid;
		b1[F_SPACEOK] = spaceValid;
		if (physOp)
		begin
			b1[F_MID_LO +: 8] = virtual_address_bits[VA_IDX_LO+8 +: 8];
			b1[F_SID_LO +: 8] = virtual_address_bits[VA_IDX_LO +: 8];
			b2 = physical_address_bits & dvmap_mask(PA_W) & ~dvmap_mask(S_LOW_LO);
		end
		else
		begin
			if (machValid || hintType)
				b1[F_MID_LO +: 8] = virtual_machine_id;
			if (spaceValid || hintType)
			begin
				b1[F_SID_LO +: 8] = address_space_id[7:0];
				if (HAS_SIDH && SID16 && NEWER)
					b1[F_SIDH_LO +: 8] = address_space_id[15:8];
			end
			if (VA_W >= 49)
				b1[F_HI1_LO +: 4] = virtual_address_bits[VA_A1 +: 4];
			if (VA_W >= 57)
				b1[F_HI2_LO +: 4] = virtual_address_bits[VA_A2 +: 4];
			b2[S_LOW_HI:S_LOW_LO] = virtual_address_bits[S_LOW_HI:S_LOW_LO];
			if (VA_W > 32)
			begin
				b2[S_VA40] = virtual_address_bits[VA_40];
				b2[S_UP_LO +: 8] = virtual_address_bits[S_UP_LO +: 8];
			end
			if (VA_W >= 49)
				b2[F_HI1_LO +: 4] = virtual_address_bits[VA_B1 +: 4];
			if (VA_W >= 57)
				b2[F_HI2_LO +: 4] = virtual_address_bits[VA_B2 +: 4];
		end
		b1 = b1 & dvmap_mask(PA_W);

		next_q = q;
		next_q.bad = !PAIR_OK;
		unique case (q.st)
			IDLE:
			begin
				next_q.ready = PAIR_OK;
				if (reqValid && q.ready)
				begin
					next_q.st = BEAT1;
					next_q.valid = 1'b1;
					next_q.addr = b1;
					next_q.last = !twoPart;
					next_q.second = b2;
					next_q.ready = 1'b0;
				end
			end
			BEAT1:
				if (link.ready)
				begin
					if (q.last)
					begin
						next_q.st = IDLE;
						next_q.valid = 1'b0;
						next_q.ready = 1'b1;
					end
					else
					begin
						next_q.st = BEAT2;
						next_q.addr = q.second;
						next_q.last = 1'b1;
					end
				end
			BEAT2:
				if (link.ready)
				begin
					next_q.st = IDLE;
					next_q.valid = 1'b0;
					next_q.ready = 1'b1;
				end
		endcase
	end

	always_ff @(posedge link.core_clk or negedge link.rst_b)
	begin
		if (!link.rst_b)
			q <= '{st: IDLE, default: '0};
		else
			q <= next_q;
	end

	assign link.valid = q.valid;
	assign link.addr  = q.addr;
	assign link.last  = q.last;
	assign reqReady   = q.ready;
	assign pairBad    = q.bad;
endmodule : dvmap_packer
`default_nettype wire

/* File: dvmap_unpacker.sv */
`timescale 1ns/10ps
`default_nettype none
// Purpose: recovers fields from one- or two-beat message addresses
// Assumes: sender follows beat order; result shown one cycle after last beat
// Notes: must-drive-zero violations are flagged, not refused
module dvmap_unpacker
	import dvmap_pkg::*;
#(
	parameter int PA_W  = 40,
	parameter int VA_W  = 32,
	parameter bit NEWER = 1'b1
)
(
	// link
	dvmap_if.receiver      link,
	// result
	input  wire logic      physOp,
	output logic           msgValid,
	output dvmap_addr_t    firstAddr,
	output logic [7:0]     virtual_machine_id,
	output logic [15:0]    address_space_id,
	output dvmap_va_t      virtual_address_bits,
	output dvmap_addr_t    physical_address_bits,
	output logic           must_drive_zero,
	output logic           pairBad
);
	typedef enum logic {WAIT1, WAIT2} dvmap_rx_e;
	typedef struct packed {
		dvmap_rx_e   st;
		dvmap_addr_t first;
		logic        out;
		dvmap_addr_t f1;
		logic [7:0]  mid;
		logic [15:0] sid;
		dvmap_va_t   va;
		dvmap_addr_t pa;
		logic        err;
		logic        bad;
	} dvmap_rx_s;

	localparam logic PAIR_OK = dvmap_pair_ok(PA_W, VA_W, NEWER);
	localparam dvmap_va_t VA_KEEP = dvmap_va_t'((58'h1 << VA_W) - 58'h1);

	dvmap_rx_s q, next_q;
	dvmap_addr_t f, s;
	logic zeroErr;
	logic hintType;

	always_comb
	begin
		next_q = q;
		next_q.out = 1'b0;
		next_q.bad = !PAIR_OK;
		f = (q.st == WAIT2) ? q.first : link.addr;
		s = (q.st == WAIT2) ? link.addr : '0;
		hintType = (f[F_TYPE_LO +: 3] == MSG_HINT);
		zeroErr = 1'b0;
		if (!hintType && !f[F_SPACEOK] && (f[F_SID_LO +: 8] != 8'h0
			|| f[F_SIDH_LO +: 8] != 8'h0))
			zeroErr = 1'b1;
		if (!hintType && !f[F_MACHOK] && f[F_MID_LO +: 8] != 8'h0)
			zeroErr = 1'b1;
		if (VA_W == 32 && s[S_UP_LO +: 8] != 8'h0)
			zeroErr = 1'b1;
		if (link.valid)
		begin
			if (q.st == WAIT1 && link.addr[F_MORE])
			begin
				next_q.st = WAIT2;
				next_q.first = link.addr;
			end
			else
			begin
				next_q.st = WAIT1;
				next_q.out = 1'b1;
				next_q.f1 = f;
				next_q.err = zeroErr;
				next_q.mid = f[F_MID_LO +: 8];
				next_q.sid = {(NEWER && PA_W >= 40) ? f[F_SIDH_LO +: 8] : 8'h0,
					f[F_SID_LO +: 8]};
				next_q.va = '0;
				next_q.pa = '0;
				if (physOp)
				begin
					next_q.pa = s & dvmap_mask(PA_W);
					next_q.va[VA_IDX_LO +: 16] = f[F_SID_LO +: 16];
				end
				else
				begin
					next_q.va[S_LOW_HI:S_LOW_LO] = s[S_LOW_HI:S_LOW_LO];
					next_q.va[VA_40] = s[S_VA40];
					next_q.va[S_UP_LO +: 8] = s[S_UP_LO +: 8];
					next_q.va[VA_B1 +: 4] = s[F_HI1_LO +: 4];
					next_q.va[VA_B2 +: 4] = s[F_HI2_LO +: 4];
					next_q.va[VA_A1 +: 4] = f[F_HI1_LO +: 4];
					next_q.va[VA_A2 +: 4] = f[F_HI2_LO +: 4];
					next_q.va = next_q.va & VA_KEEP;
				end
			end
		end
	end

	always_ff @(posedge link.core_clk or negedge link.rst_b)
	begin
		if (!link.rst_b)
			q <= '{st: WAIT1, default: '0};
		else
			q <= next_q;
	end

	assign link.ready            = 1'b1;
	assign msgValid              = q.out;
	assign firstAddr             = q.f1;
	assign virtual_machine_id    = q.mid;
	assign address_space_id      = q.sid;
	assign virtual_address_bits  = q.va;
	assign physical_address_bits = q.pa;
	assign must_drive_zero       = q.err;
	assign pairBad               = q.bad;
endmodule : dvmap_unpacker
`default_nettype wire

/* File: dvmap_monitor.sv */
// Purpose: wire checks on the message address link
// Assumes: the receiver keeps ready high
// Notes: beat position is tracked by a helper flop
`timescale 1ns/10ps
`default_nettype none
module dvmap_monitor
	import dvmap_pkg::*;
(
	// link
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        valid,
	input wire logic        ready,
	input wire dvmap_addr_t addr,
	input wire logic        last
);
	logic inSecond;
	logic first;
	logic nonHint;
	assign first = valid && !inSecond;
	assign nonHint = addr[F_TYPE_LO +: 3] != MSG_HINT;
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			inSecond <= 1'b0;
		else if (valid && ready)
			inSecond <= first && addr[F_MORE];
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	chk_last_flag: assert property (first |-> last == !addr[F_MORE])
		else $error("first beat last flag wrong");
	chk_second_last: assert property (valid && inSecond |-> last)
		else $error("second beat not last");
	chk_second_next: assert property (valid && ready && first && addr[F_MORE] |=> valid && inSecond)
		else $error("second beat late");
	chk_idle_gap: assert property (valid && ready && last |=> !valid)
		else $error("no idle after message");
	chk_space_zero: assert property (first && !addr[F_SPACEOK] && nonHint
		|-> addr[23:16] == 8'h00 && addr[39:32] == 8'h00)
		else $error("space field not zero");
	chk_mach_zero: assert property (first && !addr[F_MACHOK] && nonHint |-> addr[31:24] == 8'h00)
		else $error("machine field not zero");
	chk_second_low: assert property (valid && inSecond |-> addr[2:0] == 3'h0)
		else $error("second beat low bits set");
	chk_reset_quiet: assert property ($rose(rst_b) |-> !valid [*2])
		else $error("beat too soon after reset");
endmodule : dvmap_monitor
`default_nettype wire

/* File: dvm_message_address_packer_tb.sv */
// Purpose: drives the packer into the unpacker and checks both
// Assumes: 48-bit physical, 57-bit virtual, newer version, 16-bit space id
// Notes: expected beats and fields come from a bench model
`timescale 1ns/10ps
`default_nettype none
module dvm_message_address_packer_tb;
	import dvmap_pkg::*;
	logic        core_clk, rst_b, reqValid, physOp, twoPart, machValid, spaceValid;
	logic [11:0] ctrlBits;
	logic [2:0]  msgType;
	logic [7:0]  vmIn, vmOut;
	logic [15:0] asIn, asOut;
	dvmap_va_t   vaIn, vaOut;
	dvmap_addr_t paIn, paOut, firstAddr;
	logic        reqReady, badTx, badRx, msgValid, mdz;
	int          num_errors, checked, cycles;
	logic [31:0] seed;
	logic [48:0] beats[$];
	logic [2:0]  types[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
	dvmap_if dvmap_if_i (.core_clk(core_clk), .rst_b(rst_b));
	dvmap_packer #(.PA_W(48), .VA_W(57), .SID16(1'b1)) dvmap_packer_i (
		.link(dvmap_if_i), .reqValid(reqValid), .physOp(physOp), .twoPart(twoPart),
		.ctrlBits(ctrlBits), .msgType(msgType), .machValid(machValid), .spaceValid(spaceValid),
		.virtual_machine_id(vmIn), .address_space_id(asIn), .virtual_address_bits(vaIn),
		.physical_address_bits(paIn), .reqReady(reqReady), .pairBad(badTx));
	dvmap_unpacker #(.PA_W(48), .VA_W(57)) dvmap_unpacker_i (
		.link(dvmap_if_i), .physOp(physOp), .msgValid(msgValid), .firstAddr(firstAddr),
		.virtual_machine_id(vmOut), .address_space_id(asOut), .virtual_address_bits(vaOut),
		.physical_address_bits(paOut), .must_drive_zero(mdz), .pairBad(badRx));
	dvmap_monitor dvmap_monitor_i (.core_clk(core_clk), .rst_b(rst_b), .valid(dvmap_if_i.valid),
		.ready(dvmap_if_i.ready), .addr(dvmap_if_i.addr), .last(dvmap_if_i.last));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		xs = x ^ (x << 5);
	endfunction : xs
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic test_done;
		$display("checks %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic send(input logic ph, input logic two, input logic [2:0] ty);
		logic [63:0] r;
		logic [48:0] f, s;
		logic        mv, sv, hint;
		dvmap_va_t   va;
		dvmap_addr_t pa;
		seed = xs(seed);
		r[63:32] = seed;
		seed = xs(seed);
		r[31:0] = seed;
		mv = r[33] | ph;
		sv = r[34] | ph;
		hint = ty == MSG_HINT;
		va = two ? r[56:0] : '0;
		pa = two ? r[63:16] : '0;
		f = {!two, 36'h0, r[11:7], mv, sv, r[4:1], two};
		f[14:12] = ty;
		if (ph)
			f[31:16] = va[27:12];
		else
		begin
			f[31:24] = (mv | hint) ? r[47:40] : 8'h00;
			f[23:16] = (sv | hint) ? r[23:16] : 8'h00;
			f[39:32] = (sv | hint) ? r[31:24] : 8'h00;
			f[47:40] = {va[56:53], va[48:45]};
		end
		if (ph)
			s = {1'b1, pa[47:4], 4'h0};
		else
			s = {1'b1, va[52:49], va[44:41], va[39:4], va[40], 3'h0};
		beats.push_back(f);
		if (two)
			beats.push_back(s);
		@(posedge core_clk);
		{reqValid, physOp, twoPart, machValid, spaceValid, ctrlBits, msgType} <=
			{1'b1, ph, two, mv, sv, r[11:7], mv, sv, r[4:0], ty};
		{vmIn, asIn, vaIn, paIn} <= {r[47:40], r[31:16], va, pa};
		do @(negedge core_clk); while (!reqReady);
		@(posedge core_clk);
		reqValid <= 1'b0;
		for (int i = 0; i < 20 && msgValid !== 1'b1; i++)
			@(negedge core_clk);
		check("msgValid", msgValid, 1'b1);
		check("firstAddr", firstAddr, f[47:0]);
		check("mdz", mdz, 1'b0);
		if (ph)
		begin
			check("pa", paOut, s[47:0]);
			check("vidx", vaOut, {va[27:12], 12'h000});
		end
		else
		begin
			check("va", vaOut, {va[56:4], 4'h0});
			check("virtual_machine_id", vmOut, f[31:24]);
			check("address_space_id", asOut, {f[39:32], f[23:16]});
		end
	endtask : send
	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		cycles++;
		if (rst_b && dvmap_if_i.valid && dvmap_if_i.ready)
			check("beat", {dvmap_if_i.last, dvmap_if_i.addr}, beats.pop_front());
		if (cycles == 3000)
		begin
			num_errors++;
			test_done();
		end
	end
	initial
	begin
		{rst_b, reqValid, physOp, twoPart, machValid, spaceValid, ctrlBits, msgType} = '0;
		{vmIn, asIn, vaIn, paIn} = '0;
		{num_errors, checked, cycles} = '0;
		seed = 32'hC9753059;
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		check("pairBad tx", badTx, 1'b0);
		check("pairBad rx", badRx, 1'b0);
		for (int i = 0; i < 24; i++)
			send(1'b0, 1'b1, types[i % 6]);
		$display("virtual two-beat test done");
		for (int i = 0; i < 8; i++)
			send(1'b1, 1'b1, 3'h2);
		$display("physical test done");
		for (int i = 0; i < 6; i++)
			send(1'b0, 1'b0, types[i]);
		$display("single-beat test done");
		check("leftover beats", beats.size(), 0);
		test_done();
	end
endmodule : dvm_message_address_packer_tb
`default_nettype wire
